/* File: rx_char_if.sv */
// Received character handoff between receiver and holding path
`timescale 1ns/1ps
`default_nettype none
interface rx_char_if;
  logic       valid;
  logic [7:0] data;
  logic       frame_err;
  logic       brk;
  modport sender (output valid, output data, output frame_err, output brk);
  modport sink   (input valid, input data, input frame_err, input brk);
endinterface
`default_nettype wire

/* File: uart_channel.sv */
// One UART channel: holding path, FIFOs, status and interrupt enable
`timescale 1ns/1ps
`default_nettype none
// Function
// RULE_01: Holding write pushes data byte into transmit FIFO
// RULE_02: Holding-empty flag set when transmit FIFO empties
// RULE_03: Holding read returns and removes oldest character
// RULE_04: Falling line edge starts 16x receive counter
// RULE_05: Sample at 7.5 ticks, discard if high
// RULE_06: Enable bit 7 unmasks CTS rising interrupt
// RULE_07: Enable bit 6 unmasks RTS rising interrupt
// RULE_08: Enable bit 5 unmasks received Xoff interrupt
// RULE_09: Enable bit 4 permits sleep mode
// RULE_10: Enable bit 3 unmasks modem change interrupt
// RULE_11: Enable bit 2 unmasks receive error interrupt
// RULE_12: Enable bit 1 unmasks transmit empty interrupt
// RULE_13: Enable bit 0 unmasks receive ready interrupt
// RULE_14: Receive status shown at trigger, cleared below
// RULE_15: Data ready set on push, cleared empty
// RULE_16: Transmit-empty cleared by status read or write
// RULE_17: FIFO mode, low enables clear: no interrupts
// RULE_18: Status bit 6 when FIFO and shifter empty
// RULE_19: Status bit 7 when any stored char errored
// RULE_20: Unmasked interrupts drive channel interrupt pin
// RULE_21: Enable bits 7:4 writable only with enhanced bit
// RULE_22: Enables reset to zero, per-channel state
module uart_channel
  import uart_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Serial and modem pins
  input  wire logic        rx_pin_i,
  output logic             tx_pin_o,
  input  wire logic        clear_to_send_pin_i,
  input  wire logic        dsr_pin_i,
  input  wire logic        ri_pin_i,
  input  wire logic        dcd_pin_i,
  output logic             request_to_send_pin_o,
  // Channel outputs
  output logic             irq_out_o,
  output logic             sleep_o
);
  rx_char_if rxc ();
  uart_rx_frame u_rx (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .rx_pin_i (rx_pin_i),
    .rxo      (rxc.sender)
  );

  logic [7:0]  ier_q, fcr_q, efr_q, mcr_q, xoff_q;
  logic [7:0]  tx_mem [FIFO_DEPTH];
  logic [10:0] rx_mem [FIFO_DEPTH];
  logic [6:0]  tx_wr_q, tx_rd_q, rx_wr_q, rx_rd_q;
  logic [7:0]  tx_cnt_q, rx_cnt_q, err_cnt_q, cap, div_q;
  logic        tick16_q, tx_busy_q, tx_empty_prev_q, overrun_q;
  logic [3:0]  tx_tick_q, tx_bits_q, msy1_q, msy2_q, mprev_q, mdelta_q;
  logic [9:0]  tx_shift_q;
  logic        thre_pend_q, xoff_pend_q, cts_pend_q, rts_pend_q, rts_prev_q;
  logic        req, fire, wr, rd, wr_b0;
  logic        tx_push, tx_pop, rx_push, rx_pop, fifo_en, polled;
  logic        line_irq, rx_irq, tx_irq, modem_irq, xoff_irq, pin_irq;
  logic [7:0]  line_status, modem_status, irq_status;
  logic [10:0] rx_head;

  // Bus handshake: one wait state, side effects on the ack edge
  assign req   = wb_cyc_i & wb_stb_i;
  assign fire  = req & wb_ack_o;
  assign wr    = fire & wb_we_i;
  assign rd    = fire & ~wb_we_i;
  assign wr_b0 = wr & wb_sel_i[0];
  assign fifo_en = fcr_q[FCR_EN];
  assign cap     = fifo_en ? FIFO_DEPTH : HOLD_DEPTH;

  function automatic logic at(input logic [3:0] idx);
    at = wb_adr_i[5:2] == idx;
  endfunction

  assign tx_push = wr_b0 && at(ADR_HOLD) && tx_cnt_q < cap; // RULE_01
  assign tx_pop  = tick16_q && !tx_busy_q && tx_cnt_q != 8'h00;
  assign rx_push = rxc.valid && rx_cnt_q < cap;
  assign rx_pop  = rd && at(ADR_HOLD) && rx_cnt_q != 8'h00; // RULE_03
  assign rx_head = rx_mem[rx_rd_q];

  always_ff @(posedge clk_i) begin
    if (rst_i) wb_ack_o <= 1'b0;
    else       wb_ack_o <= req & ~wb_ack_o;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i)
      wb_dat_o <= 32'h0000_0000;
    else if (req & ~wb_ack_o & ~wb_we_i) begin
      unique case (wb_adr_i[5:2])
        ADR_HOLD: wb_dat_o <= {24'h000000, rx_head[7:0]};
        ADR_IER:  wb_dat_o <= {24'h000000, ier_q};
        ADR_ISR:  wb_dat_o <= {24'h000000, irq_status};
        ADR_LSR:  wb_dat_o <= {24'h000000, line_status};
        ADR_FCR:  wb_dat_o <= {24'h000000, fcr_q};
        ADR_EFR:  wb_dat_o <= {24'h000000, efr_q};
        ADR_MSR:  wb_dat_o <= {24'h000000, modem_status};
        ADR_MCR:  wb_dat_o <= {24'h000000, mcr_q};
        ADR_XOFF: wb_dat_o <= {24'h000000, xoff_q};
        default:  wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // Control registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ier_q  <= IER_RST; // RULE_22
      fcr_q  <= FCR_RST;
      efr_q  <= EFR_RST;
      mcr_q  <= MCR_RST;
      xoff_q <= XOFF_RST;
    end else if (wr_b0) begin
      if (at(ADR_IER)) begin
        ier_q[3:0] <= wb_dat_i[3:0];
        if (efr_q[EFR_ENH]) ier_q[7:4] <= wb_dat_i[7:4]; // RULE_21
      end
      if (at(ADR_FCR))  fcr_q  <= wb_dat_i[7:0];
      if (at(ADR_EFR))  efr_q  <= wb_dat_i[7:0];
      if (at(ADR_MCR))  mcr_q  <= wb_dat_i[7:0];
      if (at(ADR_XOFF)) xoff_q <= wb_dat_i[7:0];
    end
  end

  // Baud tick divider shared by the transmitter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_q    <= 8'h00;
      tick16_q <= 1'b0;
    end else begin
      div_q    <= (div_q == DIV16) ? 8'h00 : div_q + 8'h01;
      tick16_q <= div_q == DIV16;
    end
  end

  // Transmit FIFO; a write to a full FIFO is dropped
  always_ff @(posedge clk_i) begin
    if (tx_push) tx_mem[tx_wr_q] <= wb_dat_i[7:0]; // RULE_01
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_wr_q  <= 7'h00;
      tx_rd_q  <= 7'h00;
      tx_cnt_q <= 8'h00;
    end else begin
      if (tx_push) tx_wr_q <= tx_wr_q + 7'h01;
      if (tx_pop)  tx_rd_q <= tx_rd_q + 7'h01;
      tx_cnt_q <= tx_cnt_q + {7'h00, tx_push} - {7'h00, tx_pop};
    end
  end

  // Transmit shifter: start, eight data bits, stop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_busy_q  <= 1'b0;
      tx_tick_q  <= 4'h0;
      tx_bits_q  <= 4'h0;
      tx_shift_q <= 10'h3ff;
      tx_pin_o   <= 1'b1;
    end else begin
      if (tx_pop) begin
        tx_shift_q <= {1'b1, tx_mem[tx_rd_q], 1'b0};
        tx_busy_q  <= 1'b1;
        tx_tick_q  <= 4'h0;
        tx_bits_q  <= 4'h0;
      end else if (tick16_q && tx_busy_q) begin
        tx_tick_q <= tx_tick_q + 4'h1;
        if (tx_tick_q == 4'hf) begin
          tx_shift_q <= {1'b1, tx_shift_q[9:1]};
          tx_bits_q  <= tx_bits_q + 4'h1;
          if (tx_bits_q == 4'h9) tx_busy_q <= 1'b0;
        end
      end
      tx_pin_o <= tx_busy_q ? tx_shift_q[0] : 1'b1;
    end
  end

  // Receive FIFO holds data plus break and framing flags; the parity flag is stored as zero
  always_ff @(posedge clk_i) begin
    if (rx_push) rx_mem[rx_wr_q] <= {rxc.brk, rxc.frame_err, 1'b0, rxc.data};
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_wr_q   <= 7'h00;
      rx_rd_q   <= 7'h00;
      rx_cnt_q  <= 8'h00;
      err_cnt_q <= 8'h00;
    end else begin
      if (rx_push) rx_wr_q <= rx_wr_q + 7'h01;
      if (rx_pop)  rx_rd_q <= rx_rd_q + 7'h01; // RULE_03
      rx_cnt_q  <= rx_cnt_q + {7'h00, rx_push} - {7'h00, rx_pop};
      // Counts stored characters with errors, for status bit 7
      err_cnt_q <= err_cnt_q + {7'h00, rx_push & (rxc.brk | rxc.frame_err)}
                 - {7'h00, rx_pop & |rx_head[10:8]}; // RULE_19
    end
  end

  // Overrun is sticky; a new overrun beats the clearing read
  always_ff @(posedge clk_i) begin
    if (rst_i) overrun_q <= 1'b0;
    else if (rxc.valid && !rx_push) overrun_q <= 1'b1;
    else if (rd && at(ADR_LSR)) overrun_q <= 1'b0;
  end

  assign line_status[0] = rx_cnt_q != 8'h00; // RULE_15
  assign line_status[1] = overrun_q;
  assign line_status[4:2] = line_status[0] ? rx_head[10:8] : 3'h0;
  assign line_status[5] = tx_cnt_q == 8'h00; // RULE_02
  assign line_status[6] = line_status[5] && !tx_busy_q; // RULE_18
  assign line_status[7] = err_cnt_q != 8'h00; // RULE_19

  // Modem pins cross from outside, two flops each
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      msy1_q  <= 4'h0;
      msy2_q  <= 4'h0;
      mprev_q <= 4'h0;
    end else begin
      msy1_q  <= {dcd_pin_i, ri_pin_i, dsr_pin_i, clear_to_send_pin_i};
      msy2_q  <= msy1_q;
      mprev_q <= msy2_q;
    end
  end

  // Change bits: cts, dsr, ri trailing edge, dcd; set beats read clear
  always_ff @(posedge clk_i) begin
    if (rst_i) mdelta_q <= 4'h0;
    else mdelta_q <= (rd && at(ADR_MSR) ? 4'h0 : mdelta_q)
                   | {msy2_q[3] ^ mprev_q[3], ~msy2_q[2] & mprev_q[2],
                      msy2_q[1] ^ mprev_q[1], msy2_q[0] ^ mprev_q[0]};
  end
  assign modem_status = {msy2_q, mdelta_q};

  // Pending events cleared by a status read; a new event wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      thre_pend_q     <= 1'b0;
      xoff_pend_q     <= 1'b0;
      cts_pend_q      <= 1'b0;
      rts_pend_q      <= 1'b0;
      rts_prev_q      <= 1'b0;
      tx_empty_prev_q <= 1'b0;
    end else begin
      tx_empty_prev_q <= line_status[5];
      rts_prev_q      <= mcr_q[MCR_RTS];
      if (line_status[5] && !tx_empty_prev_q) thre_pend_q <= 1'b1;
      else if ((rd && at(ADR_ISR)) || (wr_b0 && at(ADR_HOLD))) thre_pend_q <= 1'b0; // RULE_16
      if (rx_push && rxc.data == xoff_q) xoff_pend_q <= 1'b1;
      else if (rd && at(ADR_ISR)) xoff_pend_q <= 1'b0;
      if (msy2_q[0] && !mprev_q[0]) cts_pend_q <= 1'b1;
      else if (rd && at(ADR_ISR)) cts_pend_q <= 1'b0;
      if (mcr_q[MCR_RTS] && !rts_prev_q) rts_pend_q <= 1'b1;
      else if (rd && at(ADR_ISR)) rts_pend_q <= 1'b0;
    end
  end

  // Interrupt sources behind their enables
  assign line_irq  = ier_q[IER_LINE] && |line_status[4:1]; // RULE_11
  assign rx_irq    = ier_q[IER_RX] && (fifo_en ? rx_cnt_q >= rx_trigger(fcr_q[7:6])
                                               : line_status[0]); // RULE_13
  assign tx_irq    = ier_q[IER_TX] && thre_pend_q; // RULE_12
  assign modem_irq = ier_q[IER_MODEM] && |mdelta_q; // RULE_10
  assign xoff_irq  = ier_q[IER_XOFF] && xoff_pend_q; // RULE_08
  assign pin_irq   = (ier_q[IER_CTS] && cts_pend_q) // RULE_06
                  || (ier_q[IER_RTS] && rts_pend_q); // RULE_07
  assign polled    = fifo_en && ier_q[3:0] == 4'h0;

  always_comb begin
    irq_status = ISR_NONE;
    if (line_irq)       irq_status = ISR_LINE;
    else if (rx_irq)    irq_status = ISR_RX; // RULE_14
    else if (tx_irq)    irq_status = ISR_TX;
    else if (modem_irq) irq_status = ISR_MODEM;
    else if (xoff_irq)  irq_status = ISR_XOFF;
    else if (pin_irq)   irq_status = ISR_PIN;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_out_o             <= 1'b0;
      sleep_o               <= 1'b0;
      request_to_send_pin_o <= 1'b0;
    end else begin
      irq_out_o <= !polled && irq_status != ISR_NONE; // RULE_20 RULE_17
      // Sleep only with nothing pending or in flight
      sleep_o <= ier_q[IER_SLEEP] && !line_status[0] && line_status[6] && irq_status == ISR_NONE; // RULE_09
      request_to_send_pin_o <= mcr_q[MCR_RTS];
    end
  end

  sequence hold_wr_s;
    wr_b0 && at(ADR_HOLD);
  endsequence
  tx_push_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_01
    hold_wr_s ##0 (tx_cnt_q < cap && !tx_pop) |=> tx_cnt_q == $past(tx_cnt_q) + 8'h01)
    else $error("holding write not queued");
  thre_set_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_02
    (tx_cnt_q == 8'h01 && tx_pop && !tx_push) |=> line_status[5] ##1 thre_pend_q)
    else $error("holding empty flag not set");
  rx_pop_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_03
    (rx_pop && !rx_push) |=> rx_cnt_q == $past(rx_cnt_q) - 8'h01)
    else $error("holding read did not remove character");
  data_ready_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_15
    rx_push |=> line_status[0])
    else $error("data ready not set after push");
  thre_clr_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_16
    hold_wr_s ##0 !(line_status[5] && !tx_empty_prev_q) |=> !thre_pend_q)
    else $error("transmit empty not cleared by write");
  ier_lock_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_21
    (wr_b0 && at(ADR_IER) && !efr_q[EFR_ENH]) |=> ier_q[7:4] == $past(ier_q[7:4]))
    else $error("upper enables written while locked");
  polled_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_17
    polled |=> !irq_out_o)
    else $error("interrupt raised in polled mode");
  irq_pin_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_20
    (!polled && rx_irq) |=> irq_out_o)
    else $error("unmasked receive ready not on pin");
endmodule
`default_nettype wire

/* File: uart_holding_and_irq_enable_bench.sv */
// Self-checking bench for one UART channel against a queue model
`timescale 1ns/1ps
`default_nettype none
module uart_holding_and_irq_enable_bench;
  import uart_pkg::*;
  logic        clk_i;
  logic        rst_i;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [5:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic        rxd;
  logic        txd;
  logic        cts;
  logic        dsr;
  logic        ri;
  logic        dcd;
  logic        rts;
  logic        irq;
  logic        slp;
  logic        loop;
  logic        enh;
  logic [31:0] rd;
  logic [7:0]  b0;
  logic [7:0]  b2;
  logic [7:0]  ier_m;
  logic [7:0]  rx_q[$];
  int          n_fail;
  int          checks_done;

  uart_channel dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .rx_pin_i(rxd), .tx_pin_o(txd), .clear_to_send_pin_i(cts),
    .dsr_pin_i(dsr), .ri_pin_i(ri), .dcd_pin_i(dcd),
    .request_to_send_pin_o(rts), .irq_out_o(irq), .sleep_o(slp));
  uart_line_peer peer (.clk_i(clk_i), .tx_i(txd), .loop_i(loop), .line_o(rxd));

  task automatic conclude();
    if (n_fail == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Classic single cycle; data taken at the edge that shows ack
  task automatic bus(input logic [3:0] idx, input logic w, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    sel <= 4'h1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h0, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] idx, input logic [7:0] m, input logic [7:0] e,
                        input string nm);
    bus(idx, 1'b0, 8'h00);
    check(nm, {24'h0, e}, rd & {24'h0, m});
  endtask
  task automatic wr_ier(input logic [7:0] v);
    bus(ADR_IER, 1'b1, v);
    ier_m = enh ? v : {ier_m[7:4], v[3:0]};
  endtask
  task automatic irq_is(input logic e, input int lim);
    for (int i = 0; i < lim && irq !== e; i++) @(posedge clk_i);
    check("irq_out_o", {31'h0, e}, {31'h0, irq});
  endtask
  task automatic wait_rx();
    rd = '0;
    for (int i = 0; i < 9000 && rd[0] !== 1'b1; i++) bus(ADR_LSR, 1'b0, 8'h00);
  endtask

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // Frames dominate: three of about 22k cycles each
  initial begin
    repeat (90000) @(posedge clk_i);
    n_fail++;
    conclude();
  end
  initial begin
    rst_i = 1'b1;
    {cyc, stb, we, cts, dsr, ri, dcd, loop, enh} = '0;
    adr = '0;
    sel = 4'h1;
    wdat = '0;
    ier_m = 8'h00;
    void'($urandom(43396));
    b0 = 8'($urandom);
    b2 = 8'($urandom);
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(ADR_IER, 8'hff, 8'h00, "irq_enable");
    rd_chk(4'hf, 8'hff, 8'h00, "unmapped");
    wr_ier(8'hf0);
    rd_chk(ADR_IER, 8'hff, ier_m, "irq_enable");
    bus(ADR_EFR, 1'b1, 8'h10);
    enh = 1'b1;
    wr_ier(8'($urandom));
    rd_chk(ADR_IER, 8'hff, ier_m, "irq_enable");
    wr_ier(8'h02);
    irq_is(1'b1, 8);
    rd_chk(ADR_ISR, 8'hff, ISR_TX, "irq_status");
    irq_is(1'b0, 8);
    // Transmitter looped into the receiver
    loop <= 1'b1;
    bus(ADR_HOLD, 1'b1, b0);
    rx_q.push_back(b0);
    irq_is(1'b1, 400);
    rd_chk(ADR_LSR, 8'h60, 8'h20, "line_status");
    rd_chk(ADR_ISR, 8'hff, ISR_TX, "irq_status");
    wait_rx();
    // Shifter still sends the stop bit when the character lands
    check("tx_idle", 32'h0, {31'h0, rd[6]});
    repeat (16 * DIV16_I) @(posedge clk_i);
    rd_chk(ADR_LSR, 8'h41, 8'h41, "line_status");
    wr_ier(8'h01);
    irq_is(1'b1, 8);
    rd_chk(ADR_HOLD, 8'hff, rx_q.pop_front(), "rx_holding");
    irq_is(1'b0, 8);
    rd_chk(ADR_LSR, 8'h01, 8'h00, "line_status");
    loop <= 1'b0;
    bus(ADR_FCR, 1'b1, 8'h01);
    wr_ier(8'h00);
    peer.glitch();
    repeat (16 * DIV16_I) @(posedge clk_i);
    rd_chk(ADR_LSR, 8'h01, 8'h00, "line_status");
    peer.send(XOFF_RST, 1'b1);
    rx_q.push_back(XOFF_RST);
    peer.send(b2, 1'b0);
    rx_q.push_back(b2);
    repeat (20) @(posedge clk_i);
    wr_ier(8'he0);
    repeat (8) @(posedge clk_i);
    irq_is(1'b0, 1);
    rd_chk(ADR_LSR, 8'h81, 8'h81, "line_status");
    // Error bits describe the oldest character, which arrived clean
    check("line errors", 32'h0, {31'h0, |rd[4:1]});
    wr_ier(8'h21);
    irq_is(1'b1, 8);
    rd_chk(ADR_ISR, 8'hff, ISR_XOFF, "irq_status");
    rd_chk(ADR_HOLD, 8'hff, rx_q.pop_front(), "rx_holding");
    wr_ier(8'h04);
    irq_is(1'b1, 8);
    rd_chk(ADR_ISR, 8'hff, ISR_LINE, "irq_status");
    rd_chk(ADR_LSR, 8'h1e, {3'h0, b2 == 8'h00, 4'h8}, "line_status");
    rd_chk(ADR_HOLD, 8'hff, rx_q.pop_front(), "rx_holding");
    rd_chk(ADR_LSR, 8'h81, 8'h00, "line_status");
    bus(ADR_FCR, 1'b1, 8'h00);
    bus(ADR_MSR, 1'b0, 8'h00);
    wr_ier(8'h80);
    cts <= 1'b1;
    irq_is(1'b1, 8);
    rd_chk(ADR_ISR, 8'hff, ISR_PIN, "irq_status");
    irq_is(1'b0, 8);
    cts <= 1'b0;
    wr_ier(8'h40);
    cts <= 1'b1;
    repeat (8) @(posedge clk_i);
    irq_is(1'b0, 1);
    bus(ADR_MCR, 1'b1, 8'h02);
    irq_is(1'b1, 8);
    check("rts", 32'h1, {31'h0, rts});
    rd_chk(ADR_ISR, 8'hff, ISR_PIN, "irq_status");
    bus(ADR_MSR, 1'b0, 8'h00);
    wr_ier(8'h08);
    irq_is(1'b0, 8);
    dsr <= 1'b1;
    irq_is(1'b1, 8);
    rd_chk(ADR_MSR, 8'h02, 8'h02, "modem_status");
    irq_is(1'b0, 8);
    {ri, dcd} <= 2'b11;
    irq_is(1'b1, 8);
    ri <= 1'b0;
    repeat (4) @(posedge clk_i);
    // Ring reports only its trailing edge
    rd_chk(ADR_MSR, 8'hff, 8'hbc, "modem_status");
    irq_is(1'b0, 8);
    wr_ier(8'h10);
    repeat (8) @(posedge clk_i);
    check("sleep_o", 32'h1, {31'h0, slp});
    wr_ier(8'h00);
    repeat (8) @(posedge clk_i);
    check("sleep_o", 32'h0, {31'h0, slp});
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(ADR_IER, 8'hff, 8'h00, "irq_enable");
    conclude();
  end
endmodule
`default_nettype wire

/* File: uart_line_peer.sv */
// Serial line partner: drives 8N1 frames or loops the transmitter back
`timescale 1ns/1ps
`default_nettype none
module uart_line_peer
  import uart_pkg::*;
(
  // Clock
  input  wire logic clk_i,
  // Line
  input  wire logic tx_i,
  input  wire logic loop_i,
  output logic      line_o
);
  localparam int BIT_CYC = 16 * DIV16_I;
  logic drv_q;
  // Line rests high between frames, as an idle sender would leave it
  assign line_o = loop_i ? tx_i : drv_q;
  initial drv_q = 1'b1;
  // Start bit, data LSB first, then the given stop level
  task automatic send(input logic [7:0] b, input logic stop_bit);
    logic [9:0] f;
    f = {stop_bit, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      drv_q <= f[i];
      repeat (BIT_CYC) @(posedge clk_i);
    end
    // One idle edge, so back-to-back frames never drive the line twice in a step
    drv_q <= 1'b1;
    @(posedge clk_i);
  endtask
  // Low for only 4 ticks, so the mid-start sample sees high again
  task automatic glitch();
    drv_q <= 1'b0;
    repeat (4 * DIV16_I) @(posedge clk_i);
    drv_q <= 1'b1;
  endtask
endmodule
`default_nettype wire

/* File: uart_pkg.sv */
// Constants, offsets and types shared by the UART channel modules
package uart_pkg;
  localparam int unsigned CLK_HZ   = 250_000_000;
  localparam int unsigned BAUD_BPS = 115_200;
  // Cycles per 16x sample clock
  localparam int unsigned DIV16_I  = CLK_HZ / (BAUD_BPS * 16);
  localparam logic [7:0]  DIV16    = 8'(DIV16_I - 1);
  localparam logic [7:0]  HALF16   = 8'(DIV16_I / 2);
  localparam logic [3:0]  START_TICKS = 4'h7;
  localparam logic [7:0]  FIFO_DEPTH  = 8'h80;
  localparam logic [7:0]  HOLD_DEPTH  = 8'h01;
  // Word indices on the Wishbone bus, byte address is four times these
  localparam logic [3:0] ADR_HOLD  = 4'h0;
  localparam logic [3:0] ADR_IER   = 4'h1;
  localparam logic [3:0] ADR_ISR   = 4'h2;
  localparam logic [3:0] ADR_LSR   = 4'h3;
  localparam logic [3:0] ADR_FCR   = 4'h4;
  localparam logic [3:0] ADR_EFR   = 4'h5;
  localparam logic [3:0] ADR_MSR   = 4'h6;
  localparam logic [3:0] ADR_MCR   = 4'h7;
  localparam logic [3:0] ADR_XOFF  = 4'h8;
  // Field positions
  localparam int IER_CTS = 7;
  localparam int IER_RTS = 6;
  localparam int IER_XOFF = 5;
  localparam int IER_SLEEP = 4;
  localparam int IER_MODEM = 3;
  localparam int IER_LINE = 2;
  localparam int IER_TX = 1;
  localparam int IER_RX = 0;
  localparam int EFR_ENH = 4;
  localparam int FCR_EN = 0;
  localparam int MCR_RTS = 1;
  // Reset values
  localparam logic [7:0] IER_RST  = 8'h00;
  localparam logic [7:0] FCR_RST  = 8'h00;
  localparam logic [7:0] EFR_RST  = 8'h00;
  localparam logic [7:0] MCR_RST  = 8'h00;
  localparam logic [7:0] XOFF_RST = 8'h13;
  // Interrupt status codes, highest priority first
  localparam logic [7:0] ISR_LINE  = 8'h06;
  localparam logic [7:0] ISR_RX    = 8'h04;
  localparam logic [7:0] ISR_TX    = 8'h02;
  localparam logic [7:0] ISR_MODEM = 8'h00;
  localparam logic [7:0] ISR_XOFF  = 8'h10;
  localparam logic [7:0] ISR_PIN   = 8'h20;
  localparam logic [7:0] ISR_NONE  = 8'h01;
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } rx_state_t;
  function automatic logic [7:0] rx_trigger(input logic [1:0] sel);
    unique case (sel)
      2'b00: rx_trigger = 8'h08;
      2'b01: rx_trigger = 8'h10;
      2'b10: rx_trigger = 8'h18;
      2'b11: rx_trigger = 8'h1c;
    endcase
  endfunction
endpackage

/* File: uart_rx_frame.sv */
// Serial receiver with start bit validation at the 16x sample rate
`timescale 1ns/1ps
`default_nettype none
module uart_rx_frame
  import uart_pkg::*;
(
  // Clock and reset
  input  wire logic   clk_i,
  input  wire logic   rst_i,
  // Serial line
  input  wire logic   rx_pin_i,
  // Characters out
  rx_char_if.sender   rxo
);
  logic       sync1_q, sync2_q, prev_q;
  rx_state_t  state_q;
  logic [7:0] phase_q;
  logic [3:0] ticks_q;
  logic [2:0] bit_q;
  logic [7:0] shift_q;
  logic       fall, samp, start_pt;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      prev_q  <= 1'b1;
    end else begin
      sync1_q <= rx_pin_i;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  assign fall     = prev_q & ~sync2_q;
  assign start_pt = (state_q == RX_START) && ticks_q == START_TICKS && phase_q == HALF16;
  assign samp     = ticks_q == 4'h0 && phase_q == HALF16;

  // Local 16x counter, restarted by each candidate start edge
  always_ff @(posedge clk_i) begin
    if (rst_i || state_q == RX_IDLE) begin
      phase_q <= 8'h00;
      ticks_q <= 4'h0;
    end else begin
      phase_q <= (phase_q == DIV16) ? 8'h00 : phase_q + 8'h01;
      if (start_pt)
        ticks_q <= 4'h0;
      else if (phase_q == DIV16)
        ticks_q <= ticks_q + 4'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    rxo.valid <= 1'b0;
    if (rst_i) begin
      state_q       <= RX_IDLE;
      bit_q         <= 3'h0;
      shift_q       <= 8'h00;
      rxo.data      <= 8'h00;
      rxo.frame_err <= 1'b0;
      rxo.brk       <= 1'b0;
    end else begin
      unique case (state_q)
        RX_IDLE: if (fall) state_q <= RX_START; // RULE_04
        RX_START: if (start_pt) begin
          // Still low at mid bit: genuine start, else a glitch
          state_q <= sync2_q ? RX_IDLE : RX_DATA; // RULE_05
          bit_q   <= 3'h0;
        end
        RX_DATA: if (samp) begin
          shift_q <= {sync2_q, shift_q[7:1]};
          bit_q   <= bit_q + 3'h1;
          if (bit_q == 3'h7) state_q <= RX_STOP;
        end
        RX_STOP: if (samp) begin
          rxo.valid     <= 1'b1;
          rxo.data      <= shift_q;
          rxo.frame_err <= ~sync2_q;
          rxo.brk       <= ~sync2_q && shift_q == 8'h00;
          state_q       <= RX_IDLE;
        end
      endcase
    end
  end

  sequence false_start_s;
    start_pt && sync2_q;
  endsequence
  property false_start_p;
    @(posedge clk_i) disable iff (rst_i)
      false_start_s |=> state_q == RX_IDLE ##1 !rxo.valid;
  endproperty
  false_start_a: assert property (false_start_p) // RULE_05
    else $error("false start not discarded");
  start_count_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_04
    (state_q == RX_IDLE && fall) |=> state_q == RX_START && ticks_q == 4'h0)
    else $error("start edge did not start counter");
  start_time_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_05
    $rose(state_q == RX_DATA) |-> $past(ticks_q) == START_TICKS)
    else $error("start validated at wrong time");
endmodule
`default_nettype wire
